// [hdl/tmm_pkg.sv]
// Constants and types shared by the translation-buffer access block
package tmm_pkg;
   // Buffer geometry
   localparam int INSTR_XLATE_BUF_ENTRIES = 4;
   localparam int UNIFIED_XLATE_BUF_ENTRIES = 64;
   localparam int INSTR_XLATE_BUF_IDX_W = 2;
   localparam int UNIFIED_XLATE_BUF_IDX_W = 6;
   localparam int VPN_W = 22;
   localparam int PPN_W = 19;
   localparam int SPACE_IDENT_W = 8;

   // Array decode patterns
   localparam logic [7:0] IA_TAG = 8'hF2;
   localparam logic [8:0] ID_TAG = 9'h1E6;
   localparam logic [11:0] UA_TAG = 12'hF60;
   localparam logic [11:0] UD_TAG = 12'hF70;
   localparam int IA_TAG_LSB = 24;
   localparam int ID_TAG_LSB = 23;
   localparam int U_TAG_LSB = 20;
   localparam int IDX_LSB = 8;
   localparam int ASSOC_BIT = 7;

   // Data word field positions
   localparam int VPN_LSB = 10;
   localparam int PPN_LSB = 10;
   localparam int PPN_MSB = 28;
   localparam int DIRTY_A_BIT = 9;
   localparam int VALID_BIT = 8;
   localparam int SZ_HI_BIT = 7;
   localparam int PR_HI_BIT = 6;
   localparam int PR_LO_BIT = 5;
   localparam int SZ_LO_BIT = 4;
   localparam int CACHE_BIT = 3;
   localparam int DIRTY_D_BIT = 2;
   localparam int SHARE_BIT = 1;
   localparam int WT_BIT = 0;

   // Virtual windows and control region
   localparam logic [2:0] WIN_KC = 3'b100;
   localparam logic [2:0] WIN_KU = 3'b101;
   localparam logic [2:0] WIN_KM = 3'b110;
   localparam logic [5:0] CTRL_TAG = 6'h3F;
   localparam logic [2:0] CTRL_PHYS_TOP = 3'b111;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      RG_NONE, RG_IA, RG_ID, RG_UA, RG_UD
   } tmm_region_t;

   typedef enum logic [1:0] {
      RT_PASS, RT_TLB, RT_PMB, RT_CTRL
   } tmm_route_t;
endpackage

// [hdl/tmm_vpn_match.sv]
// One entry's associative comparison against a page number and space id
`timescale 1ns/100ps
`default_nettype none
module tmm_vpn_match
   import tmm_pkg::*;
(
   input wire logic [VPN_W-1:0] ent_vpn_i,
   input wire logic [1:0] ent_sz_i,
   input wire logic [SPACE_IDENT_W-1:0] ent_space_ident_i,
   input wire logic ent_sh_i,
   input wire logic ent_v_i,
   input wire logic [VPN_W-1:0] key_vpn_i,
   input wire logic [SPACE_IDENT_W-1:0] key_space_ident_i,
   output logic hit_o
);
   logic [VPN_W-1:0] mask;
   always_comb begin
      case (ent_sz_i)
         2'b00: mask = 22'h3F_FFFF;
         2'b01: mask = 22'h3F_FFFC;
         2'b10: mask = 22'h3F_FFC0;
         default: mask = 22'h3F_FC00;
      endcase
   end
   // Shared pages ignore the space id
   assign hit_o = ent_v_i && (((ent_vpn_i ^ key_vpn_i) & mask) == 22'h00_0000)
                  && (ent_sh_i || (ent_space_ident_i == key_space_ident_i));
endmodule
`default_nettype wire

// [hdl/tmm_xlate_mode.sv]
// Window classification and physical addressing mode routing
`timescale 1ns/100ps
`default_nettype none
module tmm_xlate_mode
   import tmm_pkg::*;
(
   input wire logic [31:0] vaddr_i,
   input wire logic ext_mode_i,
   input wire logic xlate_enable_i,
   input wire logic pmb_cacheable_i,
   input wire logic pmb_wt_i,
   output tmm_route_t route_o,
   output logic [31:0] phys_o,
   output logic cacheable_o,
   output logic write_through_o
);
   logic kc_win;
   logic ku_win;
   logic ctrl_win;
   logic low_win;
   assign kc_win = vaddr_i[31:29] == WIN_KC;
   assign ku_win = vaddr_i[31:29] == WIN_KU;
   assign ctrl_win = vaddr_i[31:26] == CTRL_TAG;
   assign low_win = !vaddr_i[31] || vaddr_i[31:29] == WIN_KM;

   always_comb begin
      route_o = RT_PASS;
      phys_o = vaddr_i;
      cacheable_o = 1'b0;
      write_through_o = 1'b0;
      if (ctrl_win) begin
         route_o = RT_CTRL;
         phys_o = {CTRL_PHYS_TOP, vaddr_i[28:0]};
      end else if (kc_win || ku_win) begin
         if (ext_mode_i) begin
            route_o = RT_PMB;
            cacheable_o = pmb_cacheable_i;
            write_through_o = pmb_wt_i;
         end else begin
            // Narrow mode folds both kernel windows onto the low 29 bits
            phys_o = {3'b000, vaddr_i[28:0]};
            cacheable_o = kc_win;
         end
      end else if (low_win) begin
         if (xlate_enable_i) begin
            route_o = RT_TLB;
         end else if (!ext_mode_i) begin
            phys_o = {3'b000, vaddr_i[28:0]};
         end
      end
   end
endmodule
`default_nettype wire

// [hdl/tmm_top.sv]
// Memory-mapped access to both translation buffers plus addressing mode
// Contract
// - Instruction address array reads/writes page number, valid and space id of entry.
// - Instruction address array decoded at top byte F2, entry from bits 9:8.
// - Instruction address word: page number 31:10, valid 8, space id 7:0.
// - Instruction data array decoded at bits 31:23 pattern 1E6, entry bits 9:8.
// - Instruction data word: frame 28:10, valid 8, size 7/4, protect 6, cache 3, share 1.
// - Instruction data array access moves all six data fields of the entry.
// - Unified address array decoded at bits 31:20 equal F60, entry bits 13:8.
// - Address bit 7 picks associative or indexed write on unified address array.
// - Unified address word: page 31:10, dirty 9, valid 8, space id 7:0.
// - Unified address read returns indexed entry; never associative.
// - Indexed write stores four fields; writer holds associative bit at zero.
// - Associative write compares all unified entries, updates dirty and valid on hit.
// - Associative miss changes nothing and raises no exception.
// - Instruction buffer compared in parallel; valid written on any instruction hit.
// - Hit in both buffers copies unified entry data into instruction entry.
// - Unified data array decoded at bits 31:20 equal F70, entry bits 13:8.
// - Unified data word: frame, valid, size, protect 6:5, cache, dirty, share, write-through.
// - Unified data array access moves all eight data fields.
// - Narrow 29-bit mode after reset; extension enable selects 32-bit mode.
// - Wide mode: kernel windows via mapping buffer; others via buffers or passthrough.
// - Control region forces physical top bits to 111 regardless of translation.
// - Kernel window caching fixed in narrow mode, from mapping flags in wide mode.
`timescale 1ns/100ps
`default_nettype none
module tmm_top
   import tmm_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [31:0] req_wdata_i,
   input wire logic [SPACE_IDENT_W-1:0] page_entry_high_space_ident_i,
   output logic rsp_valid_o,
   output logic [31:0] rsp_rdata_o,
   input wire logic addr_ext_enable_i,
   input wire logic xlate_enable_i,
   input wire logic [31:0] vaddr_i,
   input wire logic pmb_cacheable_i,
   input wire logic pmb_wt_i,
   output logic ext_mode_o,
   output tmm_route_t route_o,
   output logic [31:0] phys_o,
   output logic cacheable_o,
   output logic write_through_o
);
   ////////////////////////////////////////////////////////////////////////
   // Entry storage
   logic [VPN_W-1:0] i_vpn [INSTR_XLATE_BUF_ENTRIES];
   logic [SPACE_IDENT_W-1:0] i_space_ident [INSTR_XLATE_BUF_ENTRIES];
   logic [PPN_W-1:0] i_ppn [INSTR_XLATE_BUF_ENTRIES];
   logic [1:0] i_sz [INSTR_XLATE_BUF_ENTRIES];
   logic i_pr [INSTR_XLATE_BUF_ENTRIES];
   logic i_c [INSTR_XLATE_BUF_ENTRIES];
   logic i_sh [INSTR_XLATE_BUF_ENTRIES];
   logic [INSTR_XLATE_BUF_ENTRIES-1:0] i_v_reg;

   logic [VPN_W-1:0] u_vpn [UNIFIED_XLATE_BUF_ENTRIES];
   logic [SPACE_IDENT_W-1:0] u_space_ident [UNIFIED_XLATE_BUF_ENTRIES];
   logic [PPN_W-1:0] u_ppn [UNIFIED_XLATE_BUF_ENTRIES];
   logic [1:0] u_sz [UNIFIED_XLATE_BUF_ENTRIES];
   logic [1:0] u_pr [UNIFIED_XLATE_BUF_ENTRIES];
   logic u_c [UNIFIED_XLATE_BUF_ENTRIES];
   logic u_sh [UNIFIED_XLATE_BUF_ENTRIES];
   logic u_wt [UNIFIED_XLATE_BUF_ENTRIES];
   logic [UNIFIED_XLATE_BUF_ENTRIES-1:0] u_v_reg;
   logic [UNIFIED_XLATE_BUF_ENTRIES-1:0] u_d_reg;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   tmm_region_t region;
   logic [INSTR_XLATE_BUF_IDX_W-1:0] i_idx;
   logic [UNIFIED_XLATE_BUF_IDX_W-1:0] u_idx;
   logic assoc;
   logic wr;

   always_comb begin
      if (req_addr_i[31:IA_TAG_LSB] == IA_TAG) begin
         region = RG_IA;
      end else if (req_addr_i[31:ID_TAG_LSB] == ID_TAG) begin
         region = RG_ID;
      end else if (req_addr_i[31:U_TAG_LSB] == UA_TAG) begin
         region = RG_UA;
      end else if (req_addr_i[31:U_TAG_LSB] == UD_TAG) begin
         region = RG_UD;
      end else begin
         region = RG_NONE;
      end
   end

   assign i_idx = req_addr_i[IDX_LSB+INSTR_XLATE_BUF_IDX_W-1:IDX_LSB];
   assign u_idx = req_addr_i[IDX_LSB+UNIFIED_XLATE_BUF_IDX_W-1:IDX_LSB];
   assign assoc = req_addr_i[ASSOC_BIT];
   assign wr = req_valid_i && req_write_i;

   // Data word fields as written
   logic [VPN_W-1:0] w_vpn;
   logic [PPN_W-1:0] w_ppn;
   logic [1:0] w_sz;
   assign w_vpn = req_wdata_i[31:VPN_LSB];
   assign w_ppn = req_wdata_i[PPN_MSB:PPN_LSB];
   assign w_sz = {req_wdata_i[SZ_HI_BIT], req_wdata_i[SZ_LO_BIT]};

   ////////////////////////////////////////////////////////////////////////
   // Associative compare, one matcher per entry
   logic [UNIFIED_XLATE_BUF_ENTRIES-1:0] u_hit;
   logic [INSTR_XLATE_BUF_ENTRIES-1:0] i_hit;

   for (genvar g = 0; g < UNIFIED_XLATE_BUF_ENTRIES; g++) begin : g_umatch
      tmm_vpn_match u_match (
         .ent_vpn_i(u_vpn[g]),
         .ent_sz_i(u_sz[g]),
         .ent_space_ident_i(u_space_ident[g]),
         .ent_sh_i(u_sh[g]),
         .ent_v_i(u_v_reg[g]),
         .key_vpn_i(w_vpn),
         .key_space_ident_i(page_entry_high_space_ident_i),
         .hit_o(u_hit[g])
      );
   end
   for (genvar g = 0; g < INSTR_XLATE_BUF_ENTRIES; g++) begin : g_imatch
      tmm_vpn_match i_match (
         .ent_vpn_i(i_vpn[g]),
         .ent_sz_i(i_sz[g]),
         .ent_space_ident_i(i_space_ident[g]),
         .ent_sh_i(i_sh[g]),
         .ent_v_i(i_v_reg[g]),
         .key_vpn_i(w_vpn),
         .key_space_ident_i(page_entry_high_space_ident_i),
         .hit_o(i_hit[g])
      );
   end

   // Lowest hit index wins if software left duplicate mappings
   logic [UNIFIED_XLATE_BUF_IDX_W-1:0] u_first;
   logic u_any;
   always_comb begin
      u_first = '0;
      u_any = 1'b0;
      for (int k = UNIFIED_XLATE_BUF_ENTRIES - 1; k >= 0; k--) begin
         if (u_hit[k]) begin
            u_first = UNIFIED_XLATE_BUF_IDX_W'(k);
            u_any = 1'b1;
         end
      end
   end

   logic assoc_wr;
   assign assoc_wr = wr && region == RG_UA && assoc;

   ////////////////////////////////////////////////////////////////////////
   // Unified buffer updates
   always_ff @(posedge clk_i) begin
      if (wr && region == RG_UA && !assoc) begin
         u_vpn[u_idx] <= w_vpn;
         u_space_ident[u_idx] <= req_wdata_i[SPACE_IDENT_W-1:0];
      end
      if (wr && region == RG_UD) begin
         u_ppn[u_idx] <= w_ppn;
         u_sz[u_idx] <= w_sz;
         u_pr[u_idx] <= req_wdata_i[PR_HI_BIT:PR_LO_BIT];
         u_c[u_idx] <= req_wdata_i[CACHE_BIT];
         u_sh[u_idx] <= req_wdata_i[SHARE_BIT];
         u_wt[u_idx] <= req_wdata_i[WT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         u_v_reg <= '0;
         u_d_reg <= '0;
      end else if (wr && region == RG_UA && !assoc) begin
         u_v_reg[u_idx] <= req_wdata_i[VALID_BIT];
         u_d_reg[u_idx] <= req_wdata_i[DIRTY_A_BIT];
      end else if (wr && region == RG_UD) begin
         u_v_reg[u_idx] <= req_wdata_i[VALID_BIT];
         u_d_reg[u_idx] <= req_wdata_i[DIRTY_D_BIT];
      end else if (assoc_wr) begin
         // A miss leaves every entry alone and raises nothing
         for (int k = 0; k < UNIFIED_XLATE_BUF_ENTRIES; k++) begin
            if (u_hit[k]) begin
               u_v_reg[k] <= req_wdata_i[VALID_BIT];
               u_d_reg[k] <= req_wdata_i[DIRTY_A_BIT];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction buffer updates
   always_ff @(posedge clk_i) begin
      if (wr && region == RG_IA) begin
         i_vpn[i_idx] <= w_vpn;
         i_space_ident[i_idx] <= req_wdata_i[SPACE_IDENT_W-1:0];
      end else if (wr && region == RG_ID) begin
         i_ppn[i_idx] <= w_ppn;
         i_sz[i_idx] <= w_sz;
         i_pr[i_idx] <= req_wdata_i[PR_HI_BIT];
         i_c[i_idx] <= req_wdata_i[CACHE_BIT];
         i_sh[i_idx] <= req_wdata_i[SHARE_BIT];
      end else if (assoc_wr && u_any) begin
         for (int k = 0; k < INSTR_XLATE_BUF_ENTRIES; k++) begin
            if (i_hit[k]) begin
               // Only the user-write protect bit fits the narrower field
               i_vpn[k] <= u_vpn[u_first];
               i_space_ident[k] <= u_space_ident[u_first];
               i_ppn[k] <= u_ppn[u_first];
               i_sz[k] <= u_sz[u_first];
               i_pr[k] <= u_pr[u_first][1];
               i_c[k] <= u_c[u_first];
               i_sh[k] <= u_sh[u_first];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         i_v_reg <= '0;
      end else if (wr && (region == RG_IA || region == RG_ID)) begin
         i_v_reg[i_idx] <= req_wdata_i[VALID_BIT];
      end else if (assoc_wr) begin
         for (int k = 0; k < INSTR_XLATE_BUF_ENTRIES; k++) begin
            if (i_hit[k]) begin
               i_v_reg[k] <= req_wdata_i[VALID_BIT];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the request
   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = RDATA_RST;
      case (region)
         RG_IA: begin
            rdata_next[31:VPN_LSB] = i_vpn[i_idx];
            rdata_next[VALID_BIT] = i_v_reg[i_idx];
            rdata_next[SPACE_IDENT_W-1:0] = i_space_ident[i_idx];
         end
         RG_ID: begin
            rdata_next[PPN_MSB:PPN_LSB] = i_ppn[i_idx];
            rdata_next[VALID_BIT] = i_v_reg[i_idx];
            rdata_next[SZ_HI_BIT] = i_sz[i_idx][1];
            rdata_next[SZ_LO_BIT] = i_sz[i_idx][0];
            rdata_next[PR_HI_BIT] = i_pr[i_idx];
            rdata_next[CACHE_BIT] = i_c[i_idx];
            rdata_next[SHARE_BIT] = i_sh[i_idx];
         end
         RG_UA: begin
            rdata_next[31:VPN_LSB] = u_vpn[u_idx];
            rdata_next[DIRTY_A_BIT] = u_d_reg[u_idx];
            rdata_next[VALID_BIT] = u_v_reg[u_idx];
            rdata_next[SPACE_IDENT_W-1:0] = u_space_ident[u_idx];
         end
         RG_UD: begin
            rdata_next[PPN_MSB:PPN_LSB] = u_ppn[u_idx];
            rdata_next[VALID_BIT] = u_v_reg[u_idx];
            rdata_next[SZ_HI_BIT] = u_sz[u_idx][1];
            rdata_next[SZ_LO_BIT] = u_sz[u_idx][0];
            rdata_next[PR_HI_BIT:PR_LO_BIT] = u_pr[u_idx];
            rdata_next[CACHE_BIT] = u_c[u_idx];
            rdata_next[DIRTY_D_BIT] = u_d_reg[u_idx];
            rdata_next[SHARE_BIT] = u_sh[u_idx];
            rdata_next[WT_BIT] = u_wt[u_idx];
         end
         default: rdata_next = RDATA_RST;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= RDATA_RST;
      end else begin
         rsp_valid_o <= req_valid_i;
         if (req_valid_i && !req_write_i) begin
            rsp_rdata_o <= rdata_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Addressing mode; only the narrow-to-wide switch is supported
   logic ext_mode_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_mode_reg <= 1'b0;
      end else if (addr_ext_enable_i) begin
         ext_mode_reg <= 1'b1;
      end
   end
   assign ext_mode_o = ext_mode_reg;

   tmm_route_t route_c;
   logic [31:0] phys_c;
   logic cache_c;
   logic wt_c;

   tmm_xlate_mode u_mode (
      .vaddr_i(vaddr_i),
      .ext_mode_i(ext_mode_reg),
      .xlate_enable_i(xlate_enable_i),
      .pmb_cacheable_i(pmb_cacheable_i),
      .pmb_wt_i(pmb_wt_i),
      .route_o(route_c),
      .phys_o(phys_c),
      .cacheable_o(cache_c),
      .write_through_o(wt_c)
   );

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         route_o <= RT_PASS;
         phys_o <= 32'h0000_0000;
         cacheable_o <= 1'b0;
         write_through_o <= 1'b0;
      end else begin
         route_o <= route_c;
         phys_o <= phys_c;
         cacheable_o <= cache_c;
         write_through_o <= wt_c;
      end
   end
endmodule
`default_nettype wire

// [test/tmm_top_properties.sv]
// Port checks for the translation-buffer access block
`timescale 1ns/100ps
`default_nettype none
module tmm_top_properties
   import tmm_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [31:0] req_addr_i,
   input wire logic rsp_valid_o,
   input wire logic [31:0] rsp_rdata_o,
   input wire logic addr_ext_enable_i,
   input wire logic [31:0] vaddr_i,
   input wire logic pmb_cacheable_i,
   input wire logic pmb_wt_i,
   input wire logic ext_mode_o,
   input wire tmm_route_t route_o,
   input wire logic [31:0] phys_o,
   input wire logic cacheable_o,
   input wire logic write_through_o
);
   logic rd;
   logic unmapped;
   assign rd = req_valid_i && !req_write_i;
   assign unmapped = req_addr_i[31:24] != IA_TAG && req_addr_i[31:23] != ID_TAG
      && req_addr_i[31:20] != UA_TAG && req_addr_i[31:20] != UD_TAG;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   ////////////////////////////////////////////////////////////////////////////
   a_rsp_follows: assert property (req_valid_i |=> rsp_valid_o)
      else $error("no response after request");
   a_rsp_spurious: assert property (!req_valid_i |=> !rsp_valid_o)
      else $error("response without request");
   a_rdata_holds: assert property (!rd |=> $stable(rsp_rdata_o))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (rd && unmapped |=> rsp_rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_idata_rsvd: assert property (rd && req_addr_i[31:23] == ID_TAG
      |=> (rsp_rdata_o & 32'hE000_0225) == 32'h0000_0000)
      else $error("instruction data reserved bits set");
   a_udata_rsvd: assert property (rd && req_addr_i[31:20] == UD_TAG
      |=> (rsp_rdata_o & 32'hE000_0200) == 32'h0000_0000)
      else $error("unified data reserved bits set");
   a_ext_sticky: assert property (ext_mode_o |=> ext_mode_o)
      else $error("wide mode dropped");
   a_ext_rise: assert property (addr_ext_enable_i |=> ext_mode_o)
      else $error("wide mode not entered");
   a_ctrl_force: assert property (vaddr_i[31:26] == CTRL_TAG
      |=> route_o == RT_CTRL && phys_o == $past(vaddr_i))
      else $error("control region not forced");
   a_narrow_kernel: assert property (!ext_mode_o && !addr_ext_enable_i
      && vaddr_i[31:30] == 2'b10 |=> route_o == RT_PASS
      && cacheable_o == !$past(vaddr_i[29]) && phys_o[31:29] == 3'b000)
      else $error("narrow kernel window wrong");
   a_wide_pmb: assert property (ext_mode_o && vaddr_i[31:30] == 2'b10
      |=> route_o == RT_PMB && cacheable_o == $past(pmb_cacheable_i)
      && write_through_o == $past(pmb_wt_i))
      else $error("wide kernel window wrong");
endmodule
bind tmm_top tmm_top_properties u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
   .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
   .addr_ext_enable_i(addr_ext_enable_i), .vaddr_i(vaddr_i),
   .pmb_cacheable_i(pmb_cacheable_i), .pmb_wt_i(pmb_wt_i), .ext_mode_o(ext_mode_o),
   .route_o(route_o), .phys_o(phys_o), .cacheable_o(cacheable_o),
   .write_through_o(write_through_o));
`default_nettype wire

// [test/tmm_core_model.sv]
// Load/store path model issuing privileged longword accesses
`timescale 1ns/100ps
`default_nettype none
module tmm_core_model (
   input wire logic clk_i,
   input wire logic rsp_valid_i,
   input wire logic [31:0] rsp_rdata_i,
   output logic req_valid_o,
   output logic req_write_o,
   output logic [31:0] req_addr_o,
   output logic [31:0] req_wdata_o
);
   initial begin
      req_valid_o = 1'b0;
      req_write_o = 1'b0;
      req_addr_o = 32'h0000_0000;
      req_wdata_o = 32'h0000_0000;
   end
   // Writes leave the request up; caller must follow with another access
   task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      req_valid_o <= 1'b1;
      req_write_o <= w;
      req_addr_o <= {a[31:2], 2'b00};
      req_wdata_o <= w ? d : ~d;
      @(posedge clk_i);
      q = 32'h0000_0000;
      if (!w) begin
         req_valid_o <= 1'b0;
         req_addr_o <= ~a;
         @(posedge clk_i);
         q = rsp_valid_i ? rsp_rdata_i : 'x;
      end
   endtask
endmodule
`default_nettype wire

// [test/tmm_top_tb.sv]
// Self-checking bench for the translation-buffer access block
`timescale 1ns/100ps
`default_nettype none
module tmm_top_tb
   import tmm_pkg::*;
;
   logic clk_i, arst_n_i, req_valid, req_write, rsp_valid, ext_mode, cache_o, wt_o;
   logic ext_en, xlate_en, pmb_c, pmb_w;
   logic [31:0] req_addr, req_wdata, rsp_rdata, vaddr, phys, q;
   logic [7:0] page_entry_high;
   tmm_route_t route;
   int fail_count = 0, num_checks = 0, cyc = 0;
   logic [31:0] ua[64], ud[64], ia[4], id[4];
   logic uv[64], udt[64], iv[4];
   logic [31:0] szm[4] = '{32'hFFFF_FC00, 32'hFFFF_F000, 32'hFFFF_0000, 32'hFFF0_0000};
   logic [31:0] base[5] = '{32'hF200_0000, 32'hF300_0000, 32'hF600_0000, 32'hF700_0000,
      32'hF800_0000};
   tmm_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid),
      .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
      .page_entry_high_space_ident_i(page_entry_high), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
      .addr_ext_enable_i(ext_en), .xlate_enable_i(xlate_en), .vaddr_i(vaddr),
      .pmb_cacheable_i(pmb_c), .pmb_wt_i(pmb_w), .ext_mode_o(ext_mode), .route_o(route),
      .phys_o(phys), .cacheable_o(cache_o), .write_through_o(wt_o));
   tmm_core_model core (.clk_i(clk_i), .rsp_valid_i(rsp_valid), .rsp_rdata_i(rsp_rdata),
      .req_valid_o(req_valid), .req_write_o(req_write), .req_addr_o(req_addr),
      .req_wdata_o(req_wdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input logic [35:0] m);
      num_checks++;
      if ((got & m) !== (exp & m)) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] rd_exp(int r, int i);
      case (r)
         0: return (ia[i] & 32'hFFFF_FCFF) | {iv[i], 8'h00};
         1: return (id[i] & 32'h1FFF_FCDA) | {iv[i], 8'h00};
         2: return (ua[i] & 32'hFFFF_FCFF) | {udt[i], uv[i], 8'h00};
         3: return (ud[i] & 32'h1FFF_FCFB) | {uv[i], 5'b00000, udt[i], 2'b00};
         default: return 32'h0000_0000;
      endcase
   endfunction
   task automatic op(input logic w, input int r, input int i, input logic [31:0] d);
      logic [31:0] a;
      a = base[r] | (32'(i) << 8) | ($urandom & 32'h000F_C000);
      if (r == 2 && !w) a[7] = 1'($urandom);
      core.access(w, a, d, q);
      if (!w) chk(q, rd_exp(r, i), '1);
      if (w && r < 2) iv[i] = d[8];
      if (w && r == 0) ia[i] = d;
      if (w && r == 1) id[i] = d;
      if (w && r > 1 && r < 4) uv[i] = d[8];
      if (w && r == 2) ua[i] = d;
      if (w && r == 3) ud[i] = d;
      if (w && r > 1 && r < 4) udt[i] = r == 2 ? d[9] : d[2];
   endtask
   task automatic check_all();
      for (int r = 0; r < 4; r++)
         for (int i = 0; i < (r < 2 ? 4 : 64); i++)
            op(1'b0, r, i, 32'h0000_0000);
   endtask
   // Entry size widens the mask; shared entries skip the space id
   function automatic logic hit(logic [31:0] a, logic [31:0] dw, logic v, logic [31:0] k,
      logic [7:0] s);
      return v && ((a ^ k) & szm[{dw[7], dw[4]}]) == 0 && (dw[1] || a[7:0] == s);
   endfunction
   task automatic assoc(input logic [31:0] d, input logic [7:0] s);
      logic uh[64], ih[4];
      int hu;
      hu = -1;
      for (int i = 0; i < 64; i++) uh[i] = hit(ua[i], ud[i], uv[i], d, s);
      for (int j = 0; j < 4; j++) ih[j] = hit(ia[j], id[j], iv[j], d, s);
      for (int i = 63; i >= 0; i--) if (uh[i]) hu = i;
      page_entry_high <= s;
      core.access(1'b1, base[2] | 32'h0000_0080 | ($urandom & 32'h000F_3F00), d, q);
      for (int i = 0; i < 64; i++) begin
         if (uh[i]) uv[i] = d[8];
         if (uh[i]) udt[i] = d[9];
      end
      for (int j = 0; j < 4; j++) begin
         if (ih[j]) iv[j] = d[8];
         if (ih[j] && hu >= 0) ia[j] = ua[hu];
         if (ih[j] && hu >= 0) id[j] = ud[hu];
      end
   endtask
   function automatic logic [35:0] mexp(logic [31:0] v, logic x, logic pc, logic pw, logic e);
      logic [31:0] n;
      n = {3'b000, v[28:0]};
      if (v[31:26] == 6'h3F) return {RT_CTRL, 3'b111, v[28:0], 2'b00};
      if (v[31:30] == 2'b10) return e ? {RT_PMB, v, pc, pw} : {RT_PASS, n, !v[29], 1'b0};
      if (!v[31] || v[31:29] == 3'b110) return x ? {RT_TLB, v, 2'b00} : {RT_PASS, e ? v : n, 2'b00};
      return {RT_PASS, v, 2'b00};
   endfunction
   task automatic mode_run(input int n);
      logic [35:0] mx, mp;
      logic [31:0] v;
      logic x, c, wv;
      for (int t = 0; t <= n; t++) begin
         v = $urandom;
         x = 1'($urandom);
         c = 1'($urandom);
         wv = 1'($urandom);
         vaddr <= v;
         xlate_en <= x;
         // Mapping flags stand for an entry kept inside the kernel windows
         pmb_c <= c;
         pmb_w <= wv;
         mp = mx;
         mx = mexp(v, x, c, wv, ext_en);
         @(negedge clk_i);
         if (t > 0) chk({route, phys, cache_o, wt_o}, mp, '1);
         @(posedge clk_i);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Hang guard well above the few thousand cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      logic [31:0] k;
      logic [7:0] s;
      arst_n_i = 1'b0;
      ext_en = 1'b0;
      xlate_en = 1'b0;
      vaddr = 32'h0000_0000;
      pmb_c = 1'b0;
      pmb_w = 1'b0;
      page_entry_high = 8'h00;
      void'($urandom(57));
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      chk(ext_mode, 1'b0, 1);
      core.access(1'b0, base[2] | 32'h0000_0500, 32'h0000_0000, q);
      chk(q, 0, 36'h300);
      for (int r = 0; r < 4; r++)
         for (int i = 0; i < (r < 2 ? 4 : 64); i++)
            op(1'b1, r, i, $urandom);
      check_all();
      for (int n = 0; n < 200; n++) begin
         k = ($urandom % 2 || n % 8 == 0) ? ua[$urandom % 64] : ia[$urandom % 4];
         s = ($urandom % 2 || n % 8 == 0) ? k[7:0] : 8'($urandom);
         // Plant a twin of a unified entry so both buffers can hit together
         if (n % 8 == 0) op(1'b1, 0, n % 4, k | 32'h0000_0100);
         k[9:0] = 10'($urandom);
         if ($urandom % 4 == 0) k[19:10] = 10'($urandom);
         assoc(k, s);
      end
      op(1'b1, 4, 1, $urandom);
      op(1'b0, 4, 1, 32'h0000_0000);
      check_all();
      mode_run(1000);
      ext_en <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(ext_mode, 1'b1, 1);
      mode_run(1000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
